// ### rtl/evt_pkg.sv
// Purpose: Shared constants and types for the event prioritizer and vectoring unit.
// Assumes: Event bit i carries priority number i+1; bit 0 (reset) comes from reset_i only.
// Notes: Handler offsets are ORed onto the vector base by the top module.
// How it works
// - Debug request enters debug unless debug mask set.
// - Debug entry sets debug flag, jumps to handler.
// - Debug saves return address/status in debug copies.
// - Debug mode: mode bits free, full privilege kept.
// - Debug return restores context from debug copies.
// - Reset highest priority; fetch starts at boot flash.
// - Scall and region-miss handlers get widely spaced slots.
// - Other exceptions use own fixed base offset.
// - Protection violations vector to 0x18, 0x3c, 0x40.
// - No-region match raises instruction/data miss exceptions.
// - Multiple region hit raises unmaskable fourth-rank error.
// - Interrupt levels 3..0 use autovector, below NMI.
// - Autovector offset is fourteen bits wide.
// - Lowest priority number wins on one instruction.
// - Oldest instruction's events are handled first.
// - Debugger stop ranks second, handler from debugger.
// - Bus errors, NMI, interrupts save first uncompleted.
// - Instruction faults save the offending instruction address.
// - Scall vectors 0x100, returns to call plus two.
// - Floating-point and data-modified slots never raised.
// - Handler address is base OR offset.
// - Interrupts mask equal and lower levels; NMI and exceptions other than scall mask all levels.
package evt_pkg;

  localparam int EV_N = 28;
  localparam int AV_W = 14;
  localparam int PRIO_W = 5;
  localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
  localparam logic [31:0] SCALL_STEP = 32'h0000_0002;

  // Event bit positions, bit i is priority number i+1.
  localparam int EV_RESET = 0;
  localparam int EV_DBG = 1;
  localparam int EV_UNREC = 2;
  localparam int EV_MHIT = 3;
  localparam int EV_BERR_D = 4;
  localparam int EV_BERR_I = 5;
  localparam int EV_NMI = 6;
  localparam int EV_INT3 = 7;
  localparam int EV_INT0 = 10;
  localparam int EV_FPU = 18;
  localparam int EV_SCALL = 20;
  localparam int EV_DMOD = 27;

  // Handler offsets from the vector base, indexed by event bit.
  localparam logic [8:0] VEC_OFF [0:EV_N-1] = '{
    9'h000, 9'h000, 9'h000, 9'h004, 9'h008, 9'h00c, 9'h010,
    9'h000, 9'h000, 9'h000, 9'h000, 9'h014, 9'h050, 9'h018,
    9'h01c, 9'h020, 9'h024, 9'h028, 9'h02c, 9'h030, 9'h100,
    9'h034, 9'h038, 9'h060, 9'h070, 9'h03c, 9'h040, 9'h044};

  // Bits that never reach the ranker: reset, floating-point, data-modified.
  localparam logic [EV_N-1:0] NEVER_RAISE = 28'h8040001;

  typedef enum logic [2:0] {
    MODE_APP = 3'b000,
    MODE_SUP = 3'b001,
    MODE_INT0 = 3'b010,
    MODE_INT1 = 3'b011,
    MODE_INT2 = 3'b100,
    MODE_INT3 = 3'b101,
    MODE_EXC = 3'b110,
    MODE_NMI = 3'b111
  } mode_e;

  typedef struct packed {
    logic debug_state_flag;
    logic debug_mask_bit;
    mode_e mode;
    logic exc_mask;
    logic glob_mask;
    logic [3:0] int_mask;
  } status_s;

  localparam status_s SR_RESET = '{debug_state_flag: 1'b0, debug_mask_bit: 1'b0,
    mode: MODE_SUP, exc_mask: 1'b1, glob_mask: 1'b1, int_mask: 4'h0};

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [EV_N-1:0] evt;
  } slot_s;

  typedef struct packed {
    logic push;
    logic young;
    logic [PRIO_W-1:0] prio;
    logic [31:0] ret_addr;
    status_s saved_sr;
  } accept_s;

  typedef enum logic [1:0] {
    FL_BOOT = 2'b00,
    FL_RUN = 2'b01,
    FL_SETTLE = 2'b10
  } flow_e;

endpackage

// ### rtl/evt_rank.sv
// Purpose: Fixed-priority ranker, lowest set bit index wins.
// Assumes: Request vector already masked.
// Notes: Purely combinational.
`timescale 1ns/1ps
module evt_rank
  import evt_pkg::*;
#(
  parameter int N = EV_N
) (
  // Requests
  input wire logic [N-1:0] req_i,
  // Result
  output logic any_o,
  output logic [PRIO_W-1:0] idx_o
);

  // The index must fit the priority field.
  initial begin
    if (N < 1 || N > (1 << PRIO_W)) begin
      $error("evt_rank: N out of range");
    end
  end

  assign any_o = |req_i;

  // Scan from the weakest end so the strongest request overwrites last.
  always_comb begin
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = PRIO_W'(i);
      end
    end
  end

endmodule // evt_rank

// ### rtl/cpu_event_prioritizer_vectoring.sv
// Purpose: Ranks pipeline events, enters and leaves debug, forms handler addresses.
// Assumes: Slot inputs are synchronous to sys_clk_i; sources hold requests until taken.
// Notes: One idle cycle follows every redirect so held requests are not taken twice.
//   Returns and status writes yield to an event taken in the same cycle.
`timescale 1ns/1ps
module cpu_event_prioritizer_vectoring
  import evt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Pipeline slots, oldest first; external events ride on the oldest
  input wire slot_s old_slot_i,
  input wire slot_s young_slot_i,
  // On-chip debugger
  input wire logic dbg_req_i,
  input wire logic [31:0] dbg_vector_i,
  // Interrupt controller and vector base
  input wire logic [AV_W-1:0] int_offset_i,
  input wire logic [31:0] vector_base_i,
  // Status write and return instructions
  input wire logic sr_wr_i,
  input wire status_s sr_wdata_i,
  input wire logic rete_i,
  input wire status_s stack_sr_i,
  input wire logic [31:0] stack_pc_i,
  input wire logic retd_i,
  // Fetch redirect
  output logic redirect_o,
  output logic [31:0] target_o,
  // Accepted event
  output logic event_o,
  output accept_s accept_o,
  // Status and debug copies
  output status_s sr_o,
  output logic priv_o,
  output logic [31:0] dbg_rar_o,
  output status_s dbg_rsr_o
);

  // State registers.
  // Each output port below is driven by exactly one of these flops.
  flow_e flow_ff;
  flow_e nxt_flow;
  status_s sr_ff;
  status_s nxt_sr;
  logic priv_ff;
  logic nxt_priv;
  logic redirect_ff;
  logic nxt_redirect;
  logic [31:0] target_ff;
  logic [31:0] nxt_target;
  logic event_ff;
  logic nxt_event;
  accept_s accept_ff;
  accept_s nxt_accept;
  logic [31:0] dbg_rar_ff;
  logic [31:0] nxt_dbg_rar;
  status_s dbg_rsr_ff;
  status_s nxt_dbg_rsr;

  // Decode wires.
  logic [EV_N-1:0] mask_vec;
  logic dbg_ok;
  logic [EV_N-1:0] dbg_bit;
  logic [EV_N-1:0] old_act;
  logic [EV_N-1:0] young_act;
  logic use_young;
  logic [EV_N-1:0] pick_vec;
  logic [31:0] pick_pc;
  logic pick_any;
  logic [PRIO_W-1:0] pick_idx;
  logic in_run;
  logic take;
  logic is_dbg;
  logic is_int;
  logic is_nmi;
  logic is_scall;
  logic [1:0] int_lvl;
  logic [3:0] lvl_fill;
  logic [31:0] offset_word;
  logic [31:0] evt_target;
  logic [31:0] evt_ret;
  logic retd_go;
  logic rete_go;
  logic sw_priv;

  // Elaboration checks. The decode hard-codes four interrupt levels, a
  // nine-bit offset table and a priority field wide enough for every bit,
  // so a package edit that breaks one of these would misroute events
  // silently instead of failing loudly here.
  initial begin
    // Interrupt levels 3 down to 0 must sit on four adjacent bits.
    if (EV_INT0 - EV_INT3 != 3) begin
      $error("event unit: four adjacent interrupt levels expected");
    end
    // Every event bit index must fit the reported priority field.
    if (EV_N > (1 << PRIO_W)) begin
      $error("event unit: priority field too narrow");
    end
    // The autovector offset is zero-extended into a 32-bit word.
    if (AV_W < 1 || AV_W > 32) begin
      $error("event unit: autovector width out of range");
    end
    // Supervisor call and data-modified must stay inside the table.
    if (EV_SCALL >= EV_N || EV_DMOD != EV_N - 1) begin
      $error("event unit: event table layout mismatch");
    end
    // Reset, floating-point and data-modified never reach the ranker.
    if (!NEVER_RAISE[EV_RESET] || !NEVER_RAISE[EV_FPU] || !NEVER_RAISE[EV_DMOD]) begin
      $error("event unit: unused slots must stay blocked");
    end
  end

  // Per-bit acceptance mask: interrupt levels obey their own bit and the
  // global bit; critical events and instruction faults are never masked,
  // since an instruction fault cannot wait without stalling the pipe.
  genvar b;
  generate
    for (b = 0; b < EV_N; b++) begin : g_mask
      if (b >= EV_INT3 && b <= EV_INT0) begin : g_int
        assign mask_vec[b] = sr_ff.int_mask[EV_INT0 - b] | sr_ff.glob_mask;
      end else begin : g_fix
        assign mask_vec[b] = NEVER_RAISE[b];
      end
    end
  endgenerate

  // Debug entry is held off by the mask bit and while already in debug.
  assign dbg_ok = dbg_req_i & ~sr_ff.debug_mask_bit & ~sr_ff.debug_state_flag;
  assign dbg_bit = EV_N'(dbg_ok) << EV_DBG;

  // Active events per slot; debug stop attaches to the oldest slot.
  assign old_act = ({EV_N{old_slot_i.valid}} & old_slot_i.evt & ~mask_vec) | dbg_bit;
  assign young_act = {EV_N{young_slot_i.valid}} & young_slot_i.evt & ~mask_vec;

  // A younger slot is considered only when the oldest has nothing.
  assign use_young = ~|old_act;
  assign pick_vec = use_young ? young_act : old_act;
  assign pick_pc = use_young ? young_slot_i.pc : old_slot_i.pc;

  evt_rank #(
    .N(EV_N)
  ) u_rank (
    .req_i(pick_vec),
    .any_o(pick_any),
    .idx_o(pick_idx)
  );

  // Acceptance only in the run state, never right after a redirect.
  assign in_run = (flow_ff == FL_RUN);
  assign take = in_run & pick_any;

  // Classify the winner.
  // The index alone decides; the slot that supplied it does not matter here.
  assign is_dbg = (pick_idx == PRIO_W'(EV_DBG));
  assign is_int = (pick_idx >= PRIO_W'(EV_INT3)) && (pick_idx <= PRIO_W'(EV_INT0));
  assign is_nmi = (pick_idx == PRIO_W'(EV_NMI));
  assign is_scall = (pick_idx == PRIO_W'(EV_SCALL));

  // Interrupt level 3..0 and the mask bits of that level and below.
  assign int_lvl = 2'(PRIO_W'(EV_INT0) - pick_idx);
  assign lvl_fill = 4'((5'h02 << int_lvl) - 5'h01);

  // Offset: autovector from the controller for interrupts, table otherwise.
  assign offset_word = is_int ? {{(32 - AV_W){1'b0}}, int_offset_i}
                              : {23'h000000, VEC_OFF[pick_idx]};

  // The base is ORed, not added, so a base with low bits set aliases slots.
  assign evt_target = is_dbg ? dbg_vector_i : (vector_base_i | offset_word);

  // Pending instruction has not completed, so its own PC is both the
  // offending address and the first non-completed address.
  assign evt_ret = is_scall ? (pick_pc + SCALL_STEP) : pick_pc;

  // Returns are taken only when no event competes in the same cycle.
  // A dropped return is not remembered; the decoder must present it again.
  assign retd_go = in_run & ~pick_any & retd_i & sr_ff.debug_state_flag;
  assign rete_go = in_run & ~pick_any & ~retd_go & rete_i;

  // Software may change masks only in a privileged mode.
  assign sw_priv = sr_ff.debug_state_flag | (sr_ff.mode != MODE_APP);

  // Next status value; hardware events override returns and writes.
  always_comb begin
    nxt_sr = sr_ff;
    if (take) begin
      if (is_dbg) begin
        nxt_sr.debug_state_flag = 1'b1;
        nxt_sr.mode = MODE_EXC;
      end else if (is_scall) begin
        nxt_sr.mode = MODE_SUP;
      end else if (is_int) begin
        nxt_sr.mode = mode_e'(MODE_INT0 + {1'b0, int_lvl});
        nxt_sr.int_mask = sr_ff.int_mask | lvl_fill;
      end else begin
        nxt_sr.mode = is_nmi ? MODE_NMI : MODE_EXC;
        nxt_sr.exc_mask = 1'b1;
        nxt_sr.glob_mask = 1'b1;
        nxt_sr.int_mask = 4'hf;
      end
    end else if (retd_go) begin
      nxt_sr = dbg_rsr_ff;
    end else if (rete_go) begin
      nxt_sr = stack_sr_i;
    end else if (sr_wr_i && sw_priv) begin
      nxt_sr.debug_mask_bit = sr_wdata_i.debug_mask_bit;
      nxt_sr.exc_mask = sr_wdata_i.exc_mask;
      nxt_sr.glob_mask = sr_wdata_i.glob_mask;
      nxt_sr.int_mask = sr_wdata_i.int_mask;
      if (sr_ff.debug_state_flag) begin
        nxt_sr.mode = sr_wdata_i.mode;
      end
    end
  end

  // Privilege follows the new status; debug keeps it whatever the mode.
  assign nxt_priv = nxt_sr.debug_state_flag | (nxt_sr.mode != MODE_APP);

  // Debug copies are written only on debug entry, never pushed to stack.
  assign nxt_dbg_rar = (take && is_dbg) ? evt_ret : dbg_rar_ff;
  assign nxt_dbg_rsr = (take && is_dbg) ? sr_ff : dbg_rsr_ff;

  // Flow control: boot redirect, then run with a settle cycle after redirects.
  // The settle cycle gives each source one edge to drop a request just taken.
  always_comb begin
    case (flow_ff)
      FL_BOOT: begin
        nxt_flow = FL_SETTLE;
      end
      FL_SETTLE: begin
        nxt_flow = FL_RUN;
      end
      FL_RUN: begin
        nxt_flow = (take | retd_go | rete_go) ? FL_SETTLE : FL_RUN;
      end
      default: begin
        nxt_flow = FL_BOOT;
      end
    endcase
  end

  // Redirect pulse and its target.
  // The target holds after the pulse, so a late fetch still sees a stable value.
  assign nxt_redirect = (flow_ff == FL_BOOT) | take | retd_go | rete_go;
  always_comb begin
    if (flow_ff == FL_BOOT) begin
      nxt_target = RESET_ADDR;
    end else if (take) begin
      nxt_target = evt_target;
    end else if (retd_go) begin
      nxt_target = dbg_rar_ff;
    end else if (rete_go) begin
      nxt_target = stack_pc_i;
    end else begin
      nxt_target = target_ff;
    end
  end

  // Acceptance record; reset reports priority one with no return address.
  // Between events the record holds its last value for the stacking logic.
  assign nxt_event = (flow_ff == FL_BOOT) | take;
  always_comb begin
    nxt_accept = accept_ff;
    if (flow_ff == FL_BOOT) begin
      nxt_accept.push = 1'b0;
      nxt_accept.young = 1'b0;
      nxt_accept.prio = PRIO_W'(EV_RESET + 1);
      nxt_accept.ret_addr = '0;
      nxt_accept.saved_sr = sr_ff;
    end else if (take) begin
      nxt_accept.push = ~is_dbg;
      nxt_accept.young = use_young;
      nxt_accept.prio = pick_idx + PRIO_W'(1);
      nxt_accept.ret_addr = evt_ret;
      nxt_accept.saved_sr = sr_ff;
    end
  end

  // Flow state; reset lands in the boot state.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flow_ff <= FL_BOOT;
    end else begin
      flow_ff <= nxt_flow;
    end
  end

  // Status register and privilege.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sr_ff <= SR_RESET;
      priv_ff <= 1'b1;
    end else begin
      sr_ff <= nxt_sr;
      priv_ff <= nxt_priv;
    end
  end

  // Debug return copies.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dbg_rar_ff <= '0;
      dbg_rsr_ff <= SR_RESET;
    end else begin
      dbg_rar_ff <= nxt_dbg_rar;
      dbg_rsr_ff <= nxt_dbg_rsr;
    end
  end

  // Redirect outputs.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      redirect_ff <= 1'b0;
      target_ff <= '0;
    end else begin
      redirect_ff <= nxt_redirect;
      target_ff <= nxt_target;
    end
  end

  // Acceptance outputs.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      event_ff <= 1'b0;
      accept_ff <= '0;
    end else begin
      event_ff <= nxt_event;
      accept_ff <= nxt_accept;
    end
  end

  // Ports straight from flops.
  assign redirect_o = redirect_ff;
  assign target_o = target_ff;
  assign event_o = event_ff;
  assign accept_o = accept_ff;
  assign sr_o = sr_ff;
  assign priv_o = priv_ff;
  assign dbg_rar_o = dbg_rar_ff;
  assign dbg_rsr_o = dbg_rsr_ff;

endmodule // cpu_event_prioritizer_vectoring

// ### test/evt_partner.sv
// Purpose: Interrupt controller and debugger stand-in for the event unit.
// Assumes: Bench pulses the set inputs for one cycle.
// Notes: One level raised at a time, so one offset serves.
`timescale 1ns/1ps
module evt_partner
  import evt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Bench commands
  input wire logic dbg_set_i,
  input wire logic [3:0] int_set_i,
  // Core acceptance
  input wire logic event_i,
  input wire logic [PRIO_W-1:0] prio_i,
  // Requests
  output logic dbg_req_o,
  output logic [3:0] int_req_o,
  output logic [AV_W-1:0] offset_o
);
  // A masked request must not vanish, so it drops only once taken.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dbg_req_o <= 1'b0;
      int_req_o <= 4'h0;
    end else begin
      dbg_req_o <= dbg_set_i | (dbg_req_o & ~(event_i && prio_i == 5'h02));
      for (int l = 0; l < 4; l++) begin
        int_req_o[l] <= int_set_i[l] | (int_req_o[l] & ~(event_i && prio_i == 5'(11 - l)));
      end
    end
  end
  // Offsets stay inside fourteen bits and apart from fixed slots.
  assign offset_o = 14'h1000 | {7'h00, int_req_o[3:1], 4'h0};
endmodule // evt_partner

// ### test/cpu_event_prioritizer_vectoring_checker.sv
// Purpose: Port-level assertions for the event unit.
// Assumes: Only the top ports are visible.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module cpu_event_prioritizer_vectoring_checker
  import evt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Watched inputs
  input wire slot_s old_slot_i,
  input wire slot_s young_slot_i,
  input wire logic [31:0] dbg_vector_i,
  input wire logic [AV_W-1:0] int_offset_i,
  input wire logic [31:0] vector_base_i,
  input wire logic retd_i,
  // Watched outputs
  input wire logic redirect_o,
  input wire logic [31:0] target_o,
  input wire logic event_o,
  input wire accept_s accept_o,
  input wire status_s sr_o,
  input wire logic priv_o,
  input wire logic [31:0] dbg_rar_o,
  input wire status_s dbg_rsr_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Priority shorthands; fixed slots exclude reset, debug and interrupts.
  wire logic [PRIO_W-1:0] pr = accept_o.prio;
  wire logic irq = event_o && pr inside {[5'd8:5'd11]};
  wire logic fixed = event_o && pr > 5'd2 && !(pr inside {[5'd8:5'd11]});
  chk_reset_fetch: assert property (event_o && pr == 5'd1 |-> target_o == 32'h8000_0000 && !accept_o.push)
    else $error("reset fetch address wrong");
  chk_dbg_masked: assert property (sr_o.debug_mask_bit |=> !(event_o && pr == 5'd2))
    else $error("debug entered while masked");
  chk_dbg_entry: assert property (event_o && pr == 5'd2 |-> sr_o.debug_state_flag && target_o == $past(dbg_vector_i))
    else $error("debug entry wrong");
  chk_dbg_copies: assert property (event_o && pr == 5'd2 |-> !accept_o.push && dbg_rar_o == accept_o.ret_addr && dbg_rsr_o == $past(sr_o))
    else $error("debug copies wrong");
  chk_debug_priv: assert property (sr_o.debug_state_flag |-> priv_o)
    else $error("privilege lost in debug");
  chk_debug_return: assert property (redirect_o && !event_o && $past(retd_i) && $past(sr_o.debug_state_flag) |-> target_o == $past(dbg_rar_o) && sr_o == $past(dbg_rsr_o))
    else $error("debug return wrong");
  chk_vector_or: assert property (fixed |-> (target_o | $past(vector_base_i)) == target_o && target_o[31:9] == $past(vector_base_i[31:9]))
    else $error("handler not base or offset");
  chk_autovector: assert property (irq |-> target_o == ($past(vector_base_i) | {18'h0, $past(int_offset_i)}))
    else $error("autovector wrong");
  chk_int_masks: assert property (irq |-> 3'(sr_o.mode) == 3'(5'd13 - pr) && sr_o.int_mask[0] && sr_o.int_mask[2'(5'd11 - pr)])
    else $error("interrupt masks wrong");
  chk_scall_ret: assert property (event_o && pr == 5'd21 |-> accept_o.ret_addr == (accept_o.young ? $past(young_slot_i.pc) : $past(old_slot_i.pc)) + 32'h2)
    else $error("scall return wrong");
  chk_oldest_first: assert property (event_o && accept_o.young |-> $past(old_slot_i.evt[6:2]) == 5'h00)
    else $error("younger taken first");
  chk_never_raise: assert property (event_o |-> !(pr inside {5'd19, 5'd28}))
    else $error("unused slot raised");
  cover property (event_o && pr == 5'd2);
  cover property (event_o && accept_o.young);
  cover property (irq);
endmodule // cpu_event_prioritizer_vectoring_checker

// ### test/cpu_event_prioritizer_vectoring_tb.sv
// Purpose: Directed bench for the event unit.
// Assumes: Inputs change on the falling edge.
// Notes: Base overlaps offsets so addition shows up.
`timescale 1ns/1ps
module cpu_event_prioritizer_vectoring_tb import evt_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  slot_s old_s, young_s, old_slot;
  logic dbg_set = 1'b0, sr_wr = 1'b0, retd = 1'b0, rete = 1'b0, dbg_req, redirect_o, event_o, priv_o;
  logic [3:0] int_set = 4'h0, int_req;
  logic [AV_W-1:0] int_off;
  logic [31:0] base = 32'h0001_1004, dvec = 32'h0000_7e00, target_o, dbg_rar_o;
  status_s sr_wd, sr_o, dbg_rsr_o;
  accept_s accept_o;
  int error_cnt = 0, check_count = 0;
  bit seen;
  // Own handler offset table, indexed by event bit.
  localparam logic [8:0] off_tbl [0:27] = '{9'h0, 9'h0, 9'h0, 9'h4, 9'h8, 9'hc, 9'h10, 9'h0, 9'h0, 9'h0,
    9'h0, 9'h14, 9'h50, 9'h18, 9'h1c, 9'h20, 9'h24, 9'h28, 9'h0, 9'h30, 9'h100, 9'h34, 9'h38, 9'h60,
    9'h70, 9'h3c, 9'h40, 9'h0};
  // Interrupt levels join the oldest slot, level 3 at bit 7.
  assign old_slot = '{valid: old_s.valid, pc: old_s.pc,
    evt: old_s.evt | {17'h0, int_req[0], int_req[1], int_req[2], int_req[3], 7'h0}};
  always #50 sys_clk_i = ~sys_clk_i;
  cpu_event_prioritizer_vectoring i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .old_slot_i(old_slot),
    .young_slot_i(young_s), .dbg_req_i(dbg_req), .dbg_vector_i(dvec), .int_offset_i(int_off),
    .vector_base_i(base), .sr_wr_i(sr_wr), .sr_wdata_i(sr_wd), .rete_i(rete), .stack_sr_i(SR_RESET),
    .stack_pc_i(32'h0000_3000), .retd_i(retd), .redirect_o(redirect_o), .target_o(target_o), .event_o(event_o),
    .accept_o(accept_o), .sr_o(sr_o), .priv_o(priv_o), .dbg_rar_o(dbg_rar_o), .dbg_rsr_o(dbg_rsr_o));
  evt_partner i_partner (.clk_i(sys_clk_i), .reset_i(reset_i), .dbg_set_i(dbg_set), .int_set_i(int_set),
    .event_i(event_o), .prio_i(accept_o.prio), .dbg_req_o(dbg_req), .int_req_o(int_req), .offset_o(int_off));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait for an accept pulse, sampled mid-cycle.
  task automatic wait_ev(input int n);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(negedge sys_clk_i);
      seen = (event_o === 1'b1);
    end
  endtask
  task automatic fire(input logic [27:0] oe, ye, input logic [4:0] p, input logic [31:0] tg, ra);
    old_s.evt = oe;
    young_s.evt = ye;
    wait_ev(20);
    old_s.evt = '0;
    young_s.evt = '0;
    chk(32'(seen), 32'h1);
    if (!seen) tally_and_finish();
    chk(32'(accept_o.prio), 32'(p));
    chk(target_o, tg);
    chk(accept_o.ret_addr, ra);
  endtask
  // Absence check: nothing may be taken for eight cycles.
  task automatic quiet(input logic [27:0] oe);
    old_s.evt = oe;
    wait_ev(8);
    old_s.evt = '0;
    chk(32'(seen), 32'h0);
  endtask
  task automatic sr_write(input logic dm, input mode_e md, input logic gm, input logic [3:0] im);
    @(negedge sys_clk_i);
    sr_wd = '{debug_state_flag: 1'b0, debug_mask_bit: dm, mode: md, exc_mask: 1'b1, glob_mask: gm, int_mask: im};
    sr_wr = 1'b1;
    @(negedge sys_clk_i);
    sr_wr = 1'b0;
  endtask
  task automatic raise(input logic d, input logic [3:0] il);
    dbg_set = d;
    int_set = il;
    @(negedge sys_clk_i);
    dbg_set = 1'b0;
    int_set = 4'h0;
  endtask
  initial begin
    old_s = '{valid: 1'b1, pc: 32'h0000_2000, evt: '0};
    young_s = '{valid: 1'b1, pc: 32'h0000_2004, evt: '0};
    sr_wd = SR_RESET;
    repeat (12) @(negedge sys_clk_i);
    reset_i = 1'b0;
    wait_ev(4);
    chk(target_o, 32'h8000_0000);
    chk(32'(accept_o.prio), 32'h1);
    // Every fixed-offset exception on its own.
    for (int b = 2; b < 27; b++) begin
      if (b inside {[7:10], 18, 20}) continue;
      fire(28'h1 << b, '0, 5'(b + 1), base | {23'h0, off_tbl[b]}, 32'h2000);
      if (b == 6) chk(32'(sr_o.mode), 32'(MODE_NMI));
    end
    fire(28'h1 << 20, '0, 5'd21, base | 32'h100, 32'h2002);
    fire((28'h1 << 15) | (28'h1 << 25), '0, 5'd16, base | 32'h20, 32'h2000);
    fire(28'h1 << 25, 28'h1 << 2, 5'd26, base | 32'h3c, 32'h2000);
    fire('0, 28'h1 << 2, 5'd3, base, 32'h2004);
    chk(32'(accept_o.young), 32'h1);
    chk(32'(accept_o.push), 32'h1);
    chk(32'({sr_o.exc_mask, sr_o.glob_mask, sr_o.int_mask}), 32'h3f);
    quiet((28'h1 << 18) | (28'h1 << 27));
    // Each interrupt level through the autovector.
    for (int l = 3; l >= 0; l--) begin
      sr_write(1'b0, MODE_SUP, 1'b0, 4'h0);
      raise(1'b0, 4'h1 << l);
      fire('0, '0, 5'(11 - l), base | 32'h1000 | 32'(((1 << l) >> 1) << 4), 32'h2000);
      chk(32'(sr_o.mode), 32'(2 + l));
      chk(32'(sr_o.int_mask), 32'((1 << (l + 1)) - 1));
      chk(32'({accept_o.saved_sr.glob_mask, accept_o.saved_sr.int_mask}), 32'h0);
    end
    sr_write(1'b0, MODE_SUP, 1'b0, 4'h4);
    raise(1'b0, 4'h4);
    quiet('0);
    sr_write(1'b0, MODE_SUP, 1'b0, 4'h0);
    fire('0, '0, 5'd9, base | 32'h1020, 32'h2000);
    // Debug held off by its mask, then entered and left.
    sr_write(1'b1, MODE_SUP, 1'b1, 4'h0);
    raise(1'b1, 4'h0);
    quiet('0);
    sr_write(1'b0, MODE_SUP, 1'b1, 4'h0);
    fire('0, '0, 5'd2, dvec, 32'h2000);
    chk(32'(sr_o.debug_state_flag), 32'h1);
    chk(dbg_rar_o, 32'h2000);
    chk(32'(accept_o.push), 32'h0);
    sr_write(1'b0, MODE_APP, 1'b1, 4'h0);
    chk(32'(sr_o.mode), 32'(MODE_APP));
    chk(32'(priv_o), 32'h1);
    retd = 1'b1;
    @(negedge sys_clk_i);
    retd = 1'b0;
    chk(32'(redirect_o), 32'h1);
    chk(target_o, 32'h2000);
    chk(32'(sr_o.debug_state_flag), 32'h0);
    // Event return after the settle cycle takes the stacked values, not the debug copies.
    @(negedge sys_clk_i);
    rete = 1'b1;
    @(negedge sys_clk_i);
    rete = 1'b0;
    chk(32'(redirect_o), 32'h1);
    chk(target_o, 32'h0000_3000);
    chk(32'(sr_o), 32'(SR_RESET));
    tally_and_finish();
  end
endmodule // cpu_event_prioritizer_vectoring_tb
bind cpu_event_prioritizer_vectoring cpu_event_prioritizer_vectoring_checker i_chk (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .old_slot_i(old_slot_i), .young_slot_i(young_slot_i), .dbg_vector_i(dbg_vector_i),
  .int_offset_i(int_offset_i), .vector_base_i(vector_base_i), .retd_i(retd_i), .redirect_o(redirect_o),
  .target_o(target_o), .event_o(event_o), .accept_o(accept_o), .sr_o(sr_o), .priv_o(priv_o),
  .dbg_rar_o(dbg_rar_o), .dbg_rsr_o(dbg_rsr_o));
